/* core/lss_pkg.sv */
// constants and types shared by the low side switch control block
package lss_pkg;

  // channel counts and register widths
  localparam int NUM_CH = 8;
  localparam int NUM_HP = 6;
  localparam int CMD_W = 8;
  localparam int RX_W = 16;

  // command byte field positions
  localparam int CMD_OLE_LO_POS = 6;
  localparam int CMD_OLE_HI_POS = 7;

  // frame lengths in bits
  localparam int FRAME_SHORT = 8;
  localparam int FRAME_LONG = 16;

  // bit counter width and its saturation value
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_BYTE = 5'h08;

  // status byte index of the first returned bit
  localparam logic [2:0] STAT_TOP = 3'h7;

  // reset values
  localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;
  localparam logic [NUM_CH-1:0] FAULT_RESET = 8'h00;
  localparam logic [NUM_CH-1:0] CH_RESET = 8'h00;
  localparam logic [RX_W-1:0] RX_RESET = 16'h0000;

  // pin synchroniser layout
  localparam int SYNC_W = 30;
  localparam int SY_OL = 0;
  localparam int SY_SB = 8;
  localparam int SY_PAR = 16;
  localparam int SY_PAIR = 24;
  localparam int SY_OVP = 27;
  localparam int SY_MODE = 28;
  localparam int SY_CS = 29;
  // chip select idles high, every other pin idles low
  localparam logic [SYNC_W-1:0] SYNC_RESET = 30'h2000_0000;

  // frame tracking in the system clock domain
  typedef enum logic [2:0]
  {
    FR_IDLE = 3'b001,
    FR_ACTIVE = 3'b010,
    FR_COMMIT = 3'b100
  } lss_frame_t;

endpackage

/* core/lss_sync.sv */
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module lss_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule
`default_nettype wire

/* core/lss_ctrl.sv */
// serial and parallel control logic of the eight channel low side switch
//
// Functional notes
// - mode high: serial bits ignored, still shifted in
// - mode high: pair inputs drive channel pairs
// - pairs ignored in normal mode, override otherwise
// - mode high forces channels 6 and 7 off
// - mode high keeps serial output released
// - serial output driven only while selected
// - output changes on falling edges, msb first
// - accept 8 or 16 bit frames, msb first
// - command bits 5..0 request channels 5..0
// - bits 7,6 enable on-state open load detect
// - normal mode: channel on if serial or parallel
// - channels 6,7 parallel only, faults still reported
// - status byte: channel 7 first, channel 0 last
// - status 1 means fault, command 1 on
// - 16 bit frame returns status, then first byte
// - over-voltage forces six power channels off
// - only selected device drives serial output
// - deselect loads last byte, releases output
// - select freezes fault snapshot for the exchange
// - fault bits sticky until read out
// - serial command register cleared at reset
`timescale 1ns/1ps
`default_nettype none
module lss_ctrl
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  input wire logic mode,
  input wire logic [lss_pkg::NUM_CH-1:0] parallel_channel_inputs,
  input wire logic pair_input_ch01,
  input wire logic pair_input_ch23,
  input wire logic pair_input_ch45,
  input wire logic battery_supply_overvoltage,
  input wire logic [lss_pkg::NUM_CH-1:0] short_to_battery_sense,
  input wire logic [lss_pkg::NUM_CH-1:0] open_load_sense,
  output logic [lss_pkg::NUM_CH-1:0] switch_channels,
  output logic [lss_pkg::NUM_CH-1:0] fault_status,
  output logic [lss_pkg::CMD_W-1:0] serial_command,
  output logic frame_active
);
  import lss_pkg::*;

  // link side (serial clock domain)
  logic frame_rst_n;
  logic [RX_W-1:0] rx_shift_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [CNT_W-1:0] last_len_reg;
  logic so_bit_reg;
  logic so_bit_next;
  logic so_started_reg;

  // system side
  logic [SYNC_W-1:0] pins_sync;
  logic cs_s;
  logic mode_s;
  logic ovp_s;
  logic [2:0] pair_s;
  logic [NUM_CH-1:0] par_s;
  logic [NUM_CH-1:0] sb_s;
  logic [NUM_CH-1:0] ol_s;
  lss_frame_t frame_reg;
  lss_frame_t frame_next;
  logic [CMD_W-1:0] cmd_reg;
  logic [NUM_CH-1:0] fault_reg;
  logic [NUM_CH-1:0] fault_next;
  logic [NUM_CH-1:0] snap_reg;
  logic [NUM_CH-1:0] fault_event;
  logic [NUM_CH-1:0] fault_clear;
  logic [NUM_CH-1:0] ch_reg;
  logic [NUM_CH-1:0] ch_next;
  logic so_oe_reg;
  logic read_done;
  logic on_open_load_enable_lo;
  logic on_open_load_enable_hi;
  logic [NUM_HP-1:0] channel_command_bits;

  // every system side pin crosses two flip-flops; sclk, si and the raw cs_n drive the link side
  lss_sync #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({cs_n, mode, battery_supply_overvoltage,
        pair_input_ch45, pair_input_ch23, pair_input_ch01,
        parallel_channel_inputs, short_to_battery_sense,
        open_load_sense}),
    .q(pins_sync)
  );

  // unpack synchronised pins
  assign cs_s = pins_sync[SY_CS];
  assign mode_s = pins_sync[SY_MODE];
  assign ovp_s = pins_sync[SY_OVP];
  assign pair_s = pins_sync[SY_PAIR +: 3];
  assign par_s = pins_sync[SY_PAR +: NUM_CH];
  assign sb_s = pins_sync[SY_SB +: NUM_CH];
  assign ol_s = pins_sync[SY_OL +: NUM_CH];

  // link side: runs only while the host clocks a frame

  // frame state ends with the frame itself, since the serial clock
  // stands still once chip select is high; a glitch on the pin
  // would restart the bit count, which a clean host never produces
  assign frame_rst_n = arst_n & ~cs_n;

  // command bits shift in msb first on rising edges, in every mode
  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_shift_reg <= RX_RESET;
    end
    else
    begin
      rx_shift_reg <= {rx_shift_reg[RX_W-2:0], si};
    end
  end

  // bits received in the current frame, saturating
  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt_reg <= '0;
    end
    else if (bit_cnt_reg != CNT_MAX)
    begin
      bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
    end
  end

  // length of the last frame; survives deselection so the system
  // side can judge it once the serial clock has stopped
  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_len_reg <= '0;
    end
    else if (!frame_rst_n)
    begin
      last_len_reg <= '0;
    end
    else if (bit_cnt_reg != CNT_MAX)
    begin
      last_len_reg <= bit_cnt_reg + CNT_ONE;
    end
  end

  // first eight bits come from the frozen snapshot, channel 7 first;
  // afterwards the received stream passes through delayed by a byte,
  // which returns the first command byte of a 16 bit frame
  assign so_bit_next = (bit_cnt_reg < CNT_BYTE) ?
    snap_reg[STAT_TOP - bit_cnt_reg[2:0]] :
    rx_shift_reg[CMD_W-1];

  // output bit changes only on falling edges
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      so_bit_reg <= 1'b0;
      so_started_reg <= 1'b0;
    end
    else
    begin
      so_bit_reg <= so_bit_next;
      so_started_reg <= 1'b1;
    end
  end

  // before the first falling edge the snapshot msb is presented;
  // the snapshot is frozen for the whole frame so this is stable
  assign so_out = so_oe_reg &
    (so_started_reg ? so_bit_reg : snap_reg[STAT_TOP]);
  assign so_oe = so_oe_reg;

  // system side

  // drive only while selected and in normal mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      so_oe_reg <= 1'b0;
    end
    else
    begin
      so_oe_reg <= ~cs_s & ~mode_s;
    end
  end

  // frame tracking from the synchronised chip select
  always_comb
  begin
    frame_next = frame_reg;
    unique case (frame_reg)
      FR_IDLE:
      begin
        if (!cs_s)
        begin
          frame_next = FR_ACTIVE;
        end
      end
      FR_ACTIVE:
      begin
        if (cs_s)
        begin
          frame_next = FR_COMMIT;
        end
      end
      FR_COMMIT:
      begin
        frame_next = cs_s ? FR_IDLE : FR_ACTIVE;
      end
      default:
      begin
        frame_next = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame_reg <= FR_IDLE;
    end
    else
    begin
      frame_reg <= frame_next;
    end
  end

  // a frame of at least one byte counts as a status read; link
  // registers are quiet here since the serial clock is idle
  assign read_done = (frame_reg == FR_COMMIT) &&
    (last_len_reg >= CNT_BYTE);

  // most recent byte becomes the serial command at deselection;
  // shorter frames leave the command untouched
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_reg <= CMD_RESET;
    end
    else if (read_done)
    begin
      cmd_reg <= rx_shift_reg[CMD_W-1:0];
    end
  end

  assign channel_command_bits = cmd_reg[NUM_HP-1:0];
  assign on_open_load_enable_lo = cmd_reg[CMD_OLE_LO_POS];
  assign on_open_load_enable_hi = cmd_reg[CMD_OLE_HI_POS];

  // per channel switch state and fault qualification
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      if (gi < NUM_HP)
      begin : g_hp
        // power channel: over-voltage, then pair, then serial or pin
        always_comb
        begin
          if (ovp_s)
          begin
            ch_next[gi] = 1'b0;
          end
          else if (mode_s)
          begin
            ch_next[gi] = pair_s[gi/2];
          end
          else
          begin
            ch_next[gi] = channel_command_bits[gi] | par_s[gi];
          end
        end

        // open load seen when off, or on with detection enabled
        assign fault_event[gi] = (sb_s[gi] & ch_reg[gi]) |
          (ol_s[gi] & (~ch_reg[gi] | on_open_load_enable_lo |
          on_open_load_enable_hi));
      end
      else
      begin : g_lp
        // low power channel: own pin only, off in fail-safe mode
        always_comb
        begin
          ch_next[gi] = par_s[gi] & ~mode_s;
        end

        // no on-state open load detection here
        assign fault_event[gi] = (sb_s[gi] & ch_reg[gi]) |
          (ol_s[gi] & ~ch_reg[gi]);
      end
    end
  endgenerate

  // channel outputs come from flip-flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch_reg <= CH_RESET;
    end
    else
    begin
      ch_reg <= ch_next;
    end
  end

  // reported bits clear after a read; a new event in that cycle wins
  assign fault_clear = read_done ? snap_reg : '0;

  always_comb
  begin
    fault_next = fault_reg & ~fault_clear;
    if (frame_reg != FR_ACTIVE)
    begin
      fault_next = fault_next | fault_event;
    end
  end

  // sticky fault register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_reg <= FAULT_RESET;
    end
    else
    begin
      fault_reg <= fault_next;
    end
  end

  // snapshot follows the faults while idle and freezes at select;
  // the link side reads it only once it is frozen, a lead time the
  // host grants by keeping the clock low at select
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      snap_reg <= FAULT_RESET;
    end
    else if (frame_reg == FR_IDLE)
    begin
      snap_reg <= fault_reg;
    end
  end

  // status outputs
  assign switch_channels = ch_reg;
  assign fault_status = fault_reg;
  assign serial_command = cmd_reg;
  assign frame_active = (frame_reg == FR_ACTIVE);

endmodule
`default_nettype wire

/* verif/lss_ctrl_sva.sv */
// port-level assertions for the low side switch control block
`timescale 1ns/1ps
`default_nettype none
module lss_ctrl_sva
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic mode,
  input wire logic [lss_pkg::NUM_CH-1:0] parallel_channel_inputs,
  input wire logic pair_input_ch01,
  input wire logic pair_input_ch23,
  input wire logic pair_input_ch45,
  input wire logic battery_supply_overvoltage,
  input wire logic [lss_pkg::NUM_CH-1:0] switch_channels,
  input wire logic [lss_pkg::NUM_CH-1:0] fault_status,
  input wire logic [lss_pkg::CMD_W-1:0] serial_command,
  input wire logic frame_active
);
  import lss_pkg::*;
  wire logic [5:0] pair_w;
  wire logic ovp;
  // pair pins spread over their channel pairs
  assign pair_w = {{2{pair_input_ch45}}, {2{pair_input_ch23}},
    {2{pair_input_ch01}}};
  assign ovp = battery_supply_overvoltage;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // pins must outlast the synchronisers before outputs are judged
  sequence s_fs;
    mode [*5];
  endsequence
  sequence s_desel;
    cs_n [*5];
  endsequence
  property p_oe_cs;
    s_desel |-> !so_oe;
  endproperty
  property p_oe_md;
    s_fs |-> !so_oe;
  endproperty
  property p_lp_off;
    s_fs |-> switch_channels[7:6] == 2'b00;
  endproperty
  property p_pair;
    (mode && !ovp && $stable(pair_w)) [*5] |->
      switch_channels[5:0] == pair_w;
  endproperty
  property p_norm;
    (!mode && !ovp && $stable(parallel_channel_inputs) &&
      $stable(serial_command)) [*5] |-> switch_channels ==
      {parallel_channel_inputs[7:6],
      parallel_channel_inputs[5:0] | serial_command[5:0]};
  endproperty
  property p_ovp;
    ovp [*5] |-> switch_channels[5:0] == 6'h00;
  endproperty
  property p_rst;
    $rose(arst_n) |-> serial_command == CMD_RESET &&
      fault_status == FAULT_RESET;
  endproperty
  property p_rel;
    $fell(frame_active) |-> ##[0:3] !so_oe;
  endproperty
  property p_frz;
    frame_active && $past(frame_active) |-> $stable(fault_status);
  endproperty
  // a fault bit may only drop right after a frame ends
  property p_stk;
    (|($past(fault_status) & ~fault_status)) |-> $past(frame_active) ||
      $past(frame_active, 2) || $past(frame_active, 3);
  endproperty
  property p_edge;
    (so_oe && $past(so_oe) && !cs_n && $past(!cs_n) &&
      so_out != $past(so_out)) |-> $past(sclk) && !sclk;
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("so driven unselected");
  a_oe_md: assert property (p_oe_md) else $error("so driven in mode");
  a_lp_off: assert property (p_lp_off) else $error("ch6/7 on in mode");
  a_pair: assert property (p_pair) else $error("pair control wrong");
  a_norm: assert property (p_norm) else $error("normal control wrong");
  a_ovp: assert property (p_ovp) else $error("ovp not honoured");
  a_rst: assert property (p_rst) else $error("reset value wrong");
  a_rel: assert property (p_rel) else $error("so not released");
  a_frz: assert property (p_frz) else $error("faults moved in frame");
  a_stk: assert property (p_stk) else $error("fault dropped early");
  a_edge: assert property (p_edge) else $error("so changed off fall");
endmodule
bind lss_ctrl lss_ctrl_sva i_sva (.clk(clk), .arst_n(arst_n),
  .sclk(sclk), .cs_n(cs_n), .so_out(so_out), .so_oe(so_oe), .mode(mode),
  .parallel_channel_inputs(parallel_channel_inputs),
  .pair_input_ch01(pair_input_ch01), .pair_input_ch23(pair_input_ch23),
  .pair_input_ch45(pair_input_ch45),
  .battery_supply_overvoltage(battery_supply_overvoltage),
  .switch_channels(switch_channels), .fault_status(fault_status),
  .serial_command(serial_command), .frame_active(frame_active));
`default_nettype wire

/* verif/lss_host.sv */
// host side serial master for the switch control link
`timescale 1ns/1ps
`default_nettype none
module lss_host
(
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic so_w;
  // pull-up on the return line whenever the device lets go
  assign so_w = so_oe ? so_out : 1'b1;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // odd start offset keeps link edges off the system clock edges
  task automatic xfer(input logic [15:0] d, input int n,
    output logic [15:0] r);
    begin
      r = 16'h0000;
      #3.3 cs_n = 1'b0;
      #112;
      for (int i = n - 1; i >= 0; i--)
      begin
        si = d[i];
        #16 sclk = 1'b1;
        r = {r[14:0], so_w};
        #16 sclk = 1'b0;
      end
      #52 cs_n = 1'b1;
      si = ~si;
      #48;
    end
  endtask
endmodule
`default_nettype wire

/* verif/spi_low_side_switch_control_tb.sv */
// self-checking bench for the low side switch control block
`timescale 1ns/1ps
`default_nettype none
module spi_low_side_switch_control_tb;
  import lss_pkg::*;
  localparam logic [31:0] FC [2] = '{32'h02810684, 32'h82000202};
  logic clk, arst_n, sclk, cs_n, si, so_out, so_oe, md, ov, fa, ln;
  logic [2:0] pr;
  logic [7:0] par, sb, ol, sw, fs, sc, b1, b2;
  logic [15:0] rx;
  logic [31:0] rs;
  int err_count, num_checks;
  lss_ctrl i_dut
  (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe(so_oe), .mode(md),
    .parallel_channel_inputs(par), .pair_input_ch01(pr[0]),
    .pair_input_ch23(pr[1]), .pair_input_ch45(pr[2]),
    .battery_supply_overvoltage(ov), .short_to_battery_sense(sb),
    .open_load_sense(ol), .switch_channels(sw), .fault_status(fs),
    .serial_command(sc), .frame_active(fa)
  );
  lss_host i_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // expected channel state from the two control schemes
  function automatic logic [7:0] exp_sw(input logic m, o,
    input logic [2:0] p2, input logic [7:0] p, c);
    logic [7:0] s;
    s[7:6] = m ? 2'b00 : p[7:6];
    s[5:0] = m ? {{2{p2[2]}}, {2{p2[1]}}, {2{p2[0]}}} : p[5:0] | c[5:0];
    if (o)
      s[5:0] = 6'h00;
    return s;
  endfunction
  task automatic chk(input logic [15:0] g, e);
    begin
      num_checks++;
      if (g !== e)
      begin
        err_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic close_out;
    begin
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // watchdog against a hung run
  initial
  begin
    #600000;
    err_count++;
    close_out();
  end
  initial
  begin
    arst_n = 1'b0;
    {md, ov, pr, par, sb, ol} = '0;
    rs = 32'hda853f6a;
    err_count = 0;
    num_checks = 0;
    tk(20);
    arst_n <= 1'b1;
    tk(6);
    chk({fs, sc}, 16'h0000);
    // random frames over both schemes, iteration 3 forced to ovp
    for (int i = 0; i < 24; i++)
    begin
      rs = xs(rs);
      par <= rs[7:0];
      md <= rs[8] | (i == 3);
      ov <= (rs[9] & rs[10]) | (i == 3);
      pr <= rs[13:11];
      ln = rs[14];
      b1 = rs[23:16];
      b2 = rs[31:24];
      tk(6);
      i_host.xfer({b1, b2}, ln ? 16 : 8, rx);
      tk(8);
      chk(rx, md ? (ln ? 16'hffff : 16'h00ff) : {8'h00, ln ? b1 : 8'h00});
      chk({8'h00, sc}, {8'h00, b2});
      chk({8'h00, sw}, {8'h00, exp_sw(md, ov, pr, par, b2)});
    end
    $display("random frames done");
    md <= 1'b0;
    ov <= 1'b0;
    par <= 8'h80;
    // sticky faults, sensing gated by channel state and enables
    for (int k = 0; k < 2; k++)
    begin
      tk(6);
      i_host.xfer({8'h00, FC[k][31:24]}, 8, rx);
      tk(8);
      sb <= FC[k][23:16];
      ol <= FC[k][15:8];
      tk(6);
      sb <= 8'h00;
      ol <= 8'h00;
      tk(6);
      chk({8'h00, fs}, {8'h00, FC[k][7:0]});
      i_host.xfer(16'h0000, 8, rx);
      tk(8);
      chk(rx, {8'h00, FC[k][7:0]});
      chk({8'h00, fs}, 16'h0000);
    end
    $display("fault tests done");
    close_out();
  end
endmodule
`default_nettype wire
